// [core/hpp_fifo.sv]
`timescale 1ns/100ps
module hpp_fifo #(
    parameter int W = 16,
    parameter int D = 64
) (
    input wire logic clk,
    input wire logic rst_n,
    hpp_fifo_if.store f
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D+1);

    // storage and pointers in one state word
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [CW-1:0]       cnt;
    } hpp_fifo_s;

    hpp_fifo_s s_q;    // registered state
    hpp_fifo_s s_d;    // next state
    logic      push;   // accepted write
    logic      pop;    // accepted read

    // honest flags from the count
    assign f.wr_ready = (s_q.cnt != CW'(D));
    assign f.rd_valid = (s_q.cnt != '0);
    assign f.rd_data  = s_q.mem[s_q.rp];
    assign f.cnt      = s_q.cnt;

    // next state, full drops the push
    always_comb begin
        s_d  = s_q;
        push = f.wr_valid & f.wr_ready;
        pop  = f.rd_ready & f.rd_valid;
        if (push) begin
            s_d.mem[s_q.wp] = f.wr_data;
            s_d.wp          = s_q.wp + 1'b1;
        end
        if (pop) begin
            s_d.rp = s_q.rp + 1'b1;
        end
        s_d.cnt = s_q.cnt + CW'(push) - CW'(pop);
    end

    // register, pointers cleared by reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q.wp  <= '0;
            s_q.rp  <= '0;
            s_q.cnt <= '0;
            s_q.mem <= s_d.mem;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

// [core/hpp_fifo_if.sv]
`timescale 1ns/100ps
// word buffer carrier between the port and its buffers
interface hpp_fifo_if #(
    parameter int W = 16,
    parameter int D = 64
);
    logic                   wr_valid;   // push request
    logic                   wr_ready;   // not full
    logic [W-1:0]           wr_data;    // pushed word
    logic                   rd_valid;   // not empty
    logic                   rd_ready;   // pop request
    logic [W-1:0]           rd_data;    // head word
    logic [$clog2(D+1)-1:0] cnt;        // words held

    modport store (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data, cnt);
    modport user  (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data, cnt);
endinterface

// [core/hpp_params.svh]
// Functional notes
// RQ1: strobe-dir read: select, strobe low, dir high
// RQ2: access spans both lows, ends either rising
// RQ3: read end: empty flag mirrors transmit emptiness
// RQ4: host holds dir low during writes
// RQ5: write access samples bus every clock
// RQ6: write end: full flag mirrors receive fullness
// RQ7: deselected: bus released, strobes ignored
// RQ8: selected idle: bus keeps last value
// RQ9: separate strobes: read drives transmit byte
// RQ10: separate strobes: write latches bus byte
// RQ11: host keeps dir stable whole access
// RQ12: status pin is OR of flags
// RQ13: host polls status, reads while low
// RQ14: status low until boot block loaded
// RQ15: host reads until completion code arrives
// RQ16: load fixed boot block, then run
// RQ17: boot words arrive low byte first
// RQ18: style pin sampled at reset release
// RQ19: host sends exactly the boot word count
// RQ20: reject commands of the other radio mode
// RQ21: after boot send fixed response packet
// RQ22: receive and transmit buffers hold 64 words
// RQ23: transmit writes dropped while buffer full
// RQ24: buffer state moves on second byte
// RQ25: host lowers select and write to write
// RQ26: sampled style held until next reset
`ifndef HPP_PARAMS_SVH
`define HPP_PARAMS_SVH

`define HPP_WORD_W      16
`define HPP_FIFO_DEPTH  64
`define HPP_BOOT_WORDS  1024
`define HPP_BOOT_CNT_W  11
`define HPP_RESP_WORDS  4
`define HPP_RESP_W0     16'h84a9
`define HPP_RESP_W1     16'h6100
`define HPP_RESP_W2     16'h0220
`define HPP_RESP_W3     16'h1701
`define HPP_CMD_DMR     8'h05
`define HPP_CMD_DPMR    8'h03
`define HPP_BYTE_RST    8'h00

`endif

// [core/hpp_pkg.sv]
package hpp_pkg;
`include "hpp_params.svh"

    // bus style taken from the strap
    typedef enum logic {
        HPP_STYLE_SEP = 1'b0,   // separate read and write strobes
        HPP_STYLE_DIR = 1'b1    // common strobe plus direction
    } hpp_style_e;

    // boot sequencing
    typedef enum logic [1:0] {
        HPP_ST_BOOT = 2'b00,    // loading boot block
        HPP_ST_RESP = 2'b01,    // queuing response packet
        HPP_ST_RUN  = 2'b10     // normal operation
    } hpp_state_e;

    // radio mode chosen by the loaded code
    typedef enum logic {
        HPP_MODE_DPMR = 1'b0,
        HPP_MODE_DMR  = 1'b1
    } hpp_mode_e;

    typedef logic [`HPP_WORD_W-1:0] hpp_word_t;

    // complete state of the port block
    typedef struct packed {
        hpp_style_e                style;
        logic                      style_ok;
        hpp_state_e                st;
        logic                      rd_act;
        logic                      wr_act;
        logic                      rd_ph;
        logic                      wr_ph;
        logic [7:0]                wbyte;
        logic [7:0]                wfirst;
        logic [7:0]                dout;
        logic                      oe;
        logic [`HPP_BOOT_CNT_W-1:0] boot_cnt;
        logic                      bw_valid;
        hpp_word_t                 bw_data;
        logic [9:0]                bw_addr;
        logic [1:0]                resp_idx;
        logic                      in_full;
        logic                      out_empty;
        logic                      status;
        hpp_mode_e                 mode;
        logic                      cmd_ok;
        logic                      cmd_rej;
        logic                      rx_valid;
        hpp_word_t                 rx_word;
        logic                      tx_rdy;
    } hpp_state_s;
endpackage

// [core/hpp_top.sv]
`timescale 1ns/100ps
`include "hpp_params.svh"
module hpp_top
(
    input  wire logic            clk,
    input  wire logic            rst_n,
    // host parallel pins
    input  wire logic            port_select_n,
    input  wire logic            read_or_data_strobe_n,
    input  wire logic            write_strobe_or_dir,
    input  wire logic [7:0]      host_data_in,
    output      logic [7:0]      host_data_out,
    output      logic            host_data_oe,
    output      logic            host_status_out,
    input  wire logic            bus_style_select_pin,
    // processor transmit side
    input  wire logic            tx_wr_valid,
    input  wire hpp_pkg::hpp_word_t tx_wr_data,
    output      logic            tx_wr_ready,
    // processor receive side
    output      logic            rx_rd_valid,
    output      hpp_pkg::hpp_word_t rx_rd_data,
    input  wire logic            rx_rd_ready,
    // boot block delivery
    output      logic            boot_word_valid,
    output      hpp_pkg::hpp_word_t boot_word_data,
    output      logic [9:0]      boot_word_addr,
    output      logic            boot_done,
    // status flags
    output      logic            in_full_flag,
    output      logic            out_empty_flag,
    // radio mode and command screen
    input  wire logic            loader_is_dmr,
    input  wire logic            cmd_valid,
    input  wire logic [7:0]      cmd_type,
    output      logic            radio_mode_dmr,
    output      logic            cmd_accept,
    output      logic            cmd_reject
);
    import hpp_pkg::*;

    localparam int CW = $clog2(`HPP_FIFO_DEPTH + 1);

    hpp_state_s s_q;        // registered block state
    hpp_state_s s_d;        // next block state
    logic       sel;        // chip selected and style known
    logic       rd_now;     // read access this cycle
    logic       wr_now;     // write access this cycle
    logic       rd_end;     // read access just ended
    logic       wr_end;     // write access just ended
    hpp_word_t  word;       // assembled host word
    logic       tx_push;    // transmit buffer push
    hpp_word_t  tx_wdata;   // transmit push word
    logic       tx_pop;     // transmit buffer pop
    logic       rx_push;    // receive buffer push
    logic       rx_pop;     // receive buffer pop
    logic       tx_left;    // transmit words after this cycle

    // transmit and receive word buffers
    hpp_fifo_if #(.W(`HPP_WORD_W), .D(`HPP_FIFO_DEPTH)) tx_f ();
    hpp_fifo_if #(.W(`HPP_WORD_W), .D(`HPP_FIFO_DEPTH)) rx_f ();

    // 64-word buffers on both directions
    hpp_fifo #(.W(`HPP_WORD_W), .D(`HPP_FIFO_DEPTH)) u_tx_fifo ( // RQ22
        .clk   (clk),
        .rst_n (rst_n),
        .f     (tx_f)
    );

    hpp_fifo #(.W(`HPP_WORD_W), .D(`HPP_FIFO_DEPTH)) u_rx_fifo ( // RQ22
        .clk   (clk),
        .rst_n (rst_n),
        .f     (rx_f)
    );

    // buffer handshakes from the state logic
    assign tx_f.wr_valid = tx_push;
    assign tx_f.wr_data  = tx_wdata;
    assign tx_f.rd_ready = tx_pop;
    assign rx_f.wr_valid = rx_push;
    assign rx_f.wr_data  = word;
    assign rx_f.rd_ready = rx_pop;

    // whole next-state computation
    always_comb begin
        s_d      = s_q;
        word     = '0;
        tx_push  = 1'b0;
        tx_wdata = '0;
        tx_pop   = 1'b0;
        rx_push  = 1'b0;
        rx_pop   = 1'b0;
        tx_left  = 1'b0;

        // one-cycle pulses drop by default
        s_d.bw_valid = 1'b0;
        s_d.cmd_ok   = 1'b0;
        s_d.cmd_rej  = 1'b0;

        // strap caught once after release
        if (!s_q.style_ok) begin
            s_d.style    = hpp_style_e'(bus_style_select_pin); // RQ18
            s_d.style_ok = 1'b1; // RQ26
        end

        // strobes count only while selected
        sel = !port_select_n && s_q.style_ok; // RQ7

        // decode access by bus style
        if (s_q.style == HPP_STYLE_DIR) begin
            // common strobe, direction high reads
            rd_now = sel && !read_or_data_strobe_n && write_strobe_or_dir; // RQ1
            wr_now = sel && !read_or_data_strobe_n && !write_strobe_or_dir; // RQ4
        end else begin
            // separate read and write strobes
            rd_now = sel && !read_or_data_strobe_n; // RQ9
            wr_now = sel && !write_strobe_or_dir; // RQ10
        end

        // access lives while both lows hold
        s_d.rd_act = rd_now; // RQ2
        s_d.wr_act = wr_now; // RQ2
        rd_end     = s_q.rd_act && !rd_now; // RQ2
        wr_end     = s_q.wr_act && !wr_now; // RQ2

        // drive while selected, never during a write
        s_d.oe = sel && !wr_now; // RQ7

        // read presents current byte, high first
        if (rd_now) begin // RQ8
            s_d.dout = s_q.rd_ph ? tx_f.rd_data[7:0] : tx_f.rd_data[15:8]; // RQ9
        end

        // sample bus on every clock of a write
        if (wr_now) begin
            s_d.wbyte = host_data_in; // RQ5
        end

        // transmit side: response then processor
        case (s_q.st)
            HPP_ST_RESP: begin
                tx_push = 1'b1;
                case (s_q.resp_idx)
                    2'd0:    tx_wdata = `HPP_RESP_W0;
                    2'd1:    tx_wdata = `HPP_RESP_W1;
                    2'd2:    tx_wdata = `HPP_RESP_W2;
                    default: tx_wdata = `HPP_RESP_W3; // RQ15
                endcase
                // advance when the buffer took it
                if (tx_f.wr_ready) begin
                    s_d.resp_idx = s_q.resp_idx + 2'd1; // RQ21
                    if (s_q.resp_idx == 2'(`HPP_RESP_WORDS - 1)) begin
                        s_d.st = HPP_ST_RUN;
                    end
                end
            end
            HPP_ST_RUN: begin
                // full buffer drops the word
                tx_push  = tx_wr_valid; // RQ23
                tx_wdata = tx_wr_data;
            end
            default: tx_push = 1'b0; // boot: nothing sent
        endcase

        // new transmit data clears the empty flag
        if (tx_push && tx_f.wr_ready) begin
            s_d.out_empty = 1'b0;
        end

        // read end: byte phase, pop on second byte
        if (rd_end) begin
            s_d.rd_ph = !s_q.rd_ph;
            tx_pop    = s_q.rd_ph && tx_f.rd_valid; // RQ24
            // empty after this read; a same-cycle accepted push keeps it clear
            tx_left = (tx_f.cnt > CW'(tx_pop)) || (tx_push && tx_f.wr_ready);
            if (s_q.st != HPP_ST_BOOT) begin
                s_d.out_empty = !tx_left; // RQ3
            end
        end

        // receive output stage, processor pops
        rx_pop = rx_f.rd_valid && (!s_q.rx_valid || rx_rd_ready);
        if (rx_pop) begin
            s_d.rx_valid = 1'b1;
            s_d.rx_word  = rx_f.rd_data;
            s_d.in_full  = 1'b0;
        end else if (rx_rd_ready) begin
            s_d.rx_valid = 1'b0;
        end

        // write end: assemble byte pairs
        if (wr_end) begin
            s_d.wr_ph = !s_q.wr_ph;
            if (!s_q.wr_ph) begin
                s_d.wfirst = s_q.wbyte;
            end else if (s_q.st == HPP_ST_BOOT) begin
                // boot words low byte first
                word         = {s_q.wbyte, s_q.wfirst}; // RQ17
                s_d.bw_valid = 1'b1; // RQ16
                s_d.bw_data  = word;
                s_d.bw_addr  = s_q.boot_cnt[9:0];
                s_d.boot_cnt = s_q.boot_cnt + 1'b1;
                // last word starts execution
                if (s_q.boot_cnt == `HPP_BOOT_CNT_W'(`HPP_BOOT_WORDS - 1)) begin
                    s_d.st   = HPP_ST_RESP; // RQ16
                    s_d.mode = hpp_mode_e'(loader_is_dmr); // RQ20
                end
            end else begin
                // run words high byte first
                word    = {s_q.wfirst, s_q.wbyte};
                rx_push = 1'b1; // RQ24
            end
            // full after this write; a same-cycle pop keeps it clear
            if (s_q.st != HPP_ST_BOOT) begin
                s_d.in_full = (rx_f.cnt + CW'(rx_push && rx_f.wr_ready) - CW'(rx_pop))
                              == CW'(`HPP_FIFO_DEPTH); // RQ6
            end
        end

        // status pin held low until boot done
        s_d.status = (s_d.st != HPP_ST_BOOT) && (s_d.in_full || s_d.out_empty); // RQ12 RQ14

        // screen commands against the radio mode
        if (cmd_valid && s_q.st == HPP_ST_RUN) begin
            if ((s_q.mode == HPP_MODE_DMR && cmd_type == `HPP_CMD_DPMR) ||
                (s_q.mode == HPP_MODE_DPMR && cmd_type == `HPP_CMD_DMR)) begin
                s_d.cmd_rej = 1'b1; // RQ20
            end else begin
                s_d.cmd_ok = 1'b1;
            end
        end

        // processor may write when running and room
        s_d.tx_rdy = (s_d.st == HPP_ST_RUN) && (tx_f.cnt < CW'(`HPP_FIFO_DEPTH - 1) ||
                     (tx_f.cnt == CW'(`HPP_FIFO_DEPTH - 1) && !tx_push) || tx_pop);
    end

    // state register, synchronous reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q.style     <= HPP_STYLE_SEP;
            s_q.style_ok  <= 1'b0;
            s_q.st        <= HPP_ST_BOOT;
            s_q.rd_act    <= 1'b0;
            s_q.wr_act    <= 1'b0;
            s_q.rd_ph     <= 1'b0;
            s_q.wr_ph     <= 1'b0;
            s_q.wbyte     <= `HPP_BYTE_RST;
            s_q.wfirst    <= `HPP_BYTE_RST;
            s_q.dout      <= `HPP_BYTE_RST;
            s_q.oe        <= 1'b0;
            s_q.boot_cnt  <= '0;
            s_q.bw_valid  <= 1'b0;
            s_q.bw_data   <= '0;
            s_q.bw_addr   <= '0;
            s_q.resp_idx  <= '0;
            s_q.in_full   <= 1'b0;
            s_q.out_empty <= 1'b0;
            s_q.status    <= 1'b0; // RQ14
            s_q.mode      <= HPP_MODE_DPMR;
            s_q.cmd_ok    <= 1'b0;
            s_q.cmd_rej   <= 1'b0;
            s_q.rx_valid  <= 1'b0;
            s_q.rx_word   <= '0;
            s_q.tx_rdy    <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from state flops
    assign host_data_out   = s_q.dout;
    assign host_data_oe    = s_q.oe;
    assign host_status_out = s_q.status;
    assign tx_wr_ready     = s_q.tx_rdy;
    assign rx_rd_valid     = s_q.rx_valid;
    assign rx_rd_data      = s_q.rx_word;
    assign boot_word_valid = s_q.bw_valid;
    assign boot_word_data  = s_q.bw_data;
    assign boot_word_addr  = s_q.bw_addr;
    assign boot_done       = (s_q.st != HPP_ST_BOOT);
    assign in_full_flag    = s_q.in_full;
    assign out_empty_flag  = s_q.out_empty;
    assign radio_mode_dmr  = s_q.mode;
    assign cmd_accept      = s_q.cmd_ok;
    assign cmd_reject      = s_q.cmd_rej;
endmodule

// [testbench/hpp_host_model.sv]
`timescale 1ns/100ps
// host microcontroller on the parallel port
module hpp_host_model (
    input  wire logic       clk,
    input  wire logic       style_dir,      // 1: strobe plus direction
    input  wire logic [7:0] host_data_out,
    input  wire logic       host_data_oe,
    output      logic       port_select_n,
    output      logic       read_or_data_strobe_n,
    output      logic       write_strobe_or_dir,
    output      logic [7:0] host_data_in
);
    logic       drv = 1'b0;    // host owns the bus
    logic [7:0] val = 8'h00;   // byte the host drives

    // host, else device, else inverse of last byte
    assign host_data_in = drv ? val : (host_data_oe ? host_data_out : ~val);

    initial begin
        port_select_n = 1'b1;
        read_or_data_strobe_n = 1'b1;
        write_strobe_or_dir = 1'b1;
    end

    // one byte write; cs low stays deselected
    task automatic wr_byte(input logic [7:0] b, input logic cs);
        @(negedge clk);
        drv = 1'b1;
        val = b;
        port_select_n = !cs;
        write_strobe_or_dir = 1'b0;
        read_or_data_strobe_n = !style_dir;
        repeat (2) @(negedge clk);
        drv = 1'b0;
        read_or_data_strobe_n = 1'b1;
        write_strobe_or_dir = 1'b1;
        repeat (3) @(negedge clk);
    endtask

    // one byte read, bounded wait for the drive
    task automatic rd_byte(output logic [7:0] b);
        int n;
        @(negedge clk);
        port_select_n = 1'b0;
        write_strobe_or_dir = 1'b1;
        read_or_data_strobe_n = 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (host_data_oe !== 1'b1 && n < 8);
        @(negedge clk);
        b = host_data_in;
        read_or_data_strobe_n = 1'b1;
        repeat (3) @(negedge clk);
    endtask

    // let go of the select line
    task automatic deselect();
        @(negedge clk);
        port_select_n = 1'b1;
    endtask
endmodule

// [testbench/hpp_top_monitor.sv]
`timescale 1ns/100ps
// watches pins, flags and command answers
module hpp_top_monitor (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       port_select_n,
    input wire logic       read_or_data_strobe_n,
    input wire logic       write_strobe_or_dir,
    input wire logic [7:0] host_data_out,
    input wire logic       host_data_oe,
    input wire logic       host_status_out,
    input wire logic       boot_done,
    input wire logic       in_full_flag,
    input wire logic       out_empty_flag,
    input wire logic       cmd_valid,
    input wire logic [7:0] cmd_type,
    input wire logic       radio_mode_dmr,
    input wire logic       cmd_accept,
    input wire logic       cmd_reject,
    input wire logic       boot_word_valid
);
    logic [1:0] arm_q;  // cycles since reset release, saturating
    logic [3:0] run_q;  // cycles since boot finished, saturating

    // cycles since release and since boot end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            arm_q <= 2'h0;
            run_q <= 4'h0;
        end else begin
            if (arm_q != 2'h3) arm_q <= arm_q + 2'h1;
            if (!boot_done) run_q <= 4'h0;
            else if (run_q != 4'h8) run_q <= run_q + 4'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_DESEL_RELEASE: assert property (port_select_n |=> !host_data_oe)
        else $error("bus driven while deselected");
    AST_READ_DRIVE: assert property (arm_q == 2'h3 && !port_select_n && !read_or_data_strobe_n
        && write_strobe_or_dir |=> host_data_oe) else $error("read access not driven");
    AST_WRITE_NO_DRIVE: assert property (!port_select_n && !write_strobe_or_dir |=> !host_data_oe)
        else $error("bus driven during write");
    AST_IDLE_HOLD: assert property ((!port_select_n && read_or_data_strobe_n && write_strobe_or_dir)[*3]
        |=> $stable(host_data_out)) else $error("idle bus value moved");
    AST_STATUS_OR: assert property ($stable(in_full_flag) && $stable(out_empty_flag)
        |-> host_status_out == (in_full_flag || out_empty_flag)) else $error("status not flag or");
    AST_BOOT_STATUS_LOW: assert property (!boot_done |-> !host_status_out)
        else $error("status high before boot end");
    AST_DONE_STICKY: assert property (boot_done |=> boot_done)
        else $error("boot done dropped");
    AST_CMD_ONE_ANSWER: assert property (run_q == 4'h8 && cmd_valid |=> cmd_accept != cmd_reject)
        else $error("command not answered once");
    AST_CMD_DMR_REJ: assert property (run_q == 4'h8 && cmd_valid && radio_mode_dmr && cmd_type == 8'h03
        |=> cmd_reject) else $error("type 3 taken in dmr mode");
    AST_CMD_DPMR_REJ: assert property (run_q == 4'h8 && cmd_valid && !radio_mode_dmr && cmd_type == 8'h05
        |=> cmd_reject) else $error("type 5 taken in dpmr mode");
    AST_NO_CMD_QUIET: assert property (!cmd_valid |=> !cmd_accept && !cmd_reject)
        else $error("answer without command");

    // main scenarios reached
    cover property (boot_word_valid);
    cover property (cmd_reject);
    cover property ($rose(in_full_flag));
    cover property (host_data_oe && !read_or_data_strobe_n);
endmodule

bind hpp_top hpp_top_monitor i_hpp_top_monitor (
    .clk(clk), .rst_n(rst_n), .port_select_n(port_select_n), .read_or_data_strobe_n(read_or_data_strobe_n),
    .write_strobe_or_dir(write_strobe_or_dir), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
    .host_status_out(host_status_out), .boot_done(boot_done), .in_full_flag(in_full_flag),
    .out_empty_flag(out_empty_flag), .cmd_valid(cmd_valid), .cmd_type(cmd_type),
    .radio_mode_dmr(radio_mode_dmr), .cmd_accept(cmd_accept), .cmd_reject(cmd_reject),
    .boot_word_valid(boot_word_valid)
);

// [testbench/testbench.sv]
`timescale 1ns/100ps
module testbench;
    import hpp_pkg::*;
    localparam logic [63:0] RESP = 64'h84a9_6100_0220_1701;  // response bytes in bus order
    logic        clk = 1'b0, rst_n = 1'b0, style_pin = 1'b0, host_style = 1'b0;
    logic        sel_n, strb_n, wsd, oe, stat, tx_rdy, rx_v, bw_v, done, inf, oute, mode, acc, rej;
    logic        tx_v = 1'b0, rx_rdy = 1'b0, dmr = 1'b0, cmd_v = 1'b0;
    logic [7:0]  din, dout, cmd_t = 8'h00;
    hpp_word_t   tx_d = '0, rx_d, bw_d;
    logic [9:0]  bw_a;
    logic [31:0] bq[$], rq[$], cq[$], tq[$];  // expected notes
    int          err_count = 0, compares = 0, cyc = 0;

    hpp_top i_hpp_top (
        .clk(clk), .rst_n(rst_n), .port_select_n(sel_n), .read_or_data_strobe_n(strb_n),
        .write_strobe_or_dir(wsd), .host_data_in(din), .host_data_out(dout), .host_data_oe(oe),
        .host_status_out(stat), .bus_style_select_pin(style_pin), .tx_wr_valid(tx_v), .tx_wr_data(tx_d),
        .tx_wr_ready(tx_rdy), .rx_rd_valid(rx_v), .rx_rd_data(rx_d), .rx_rd_ready(rx_rdy),
        .boot_word_valid(bw_v), .boot_word_data(bw_d), .boot_word_addr(bw_a), .boot_done(done),
        .in_full_flag(inf), .out_empty_flag(oute), .loader_is_dmr(dmr), .cmd_valid(cmd_v),
        .cmd_type(cmd_t), .radio_mode_dmr(mode), .cmd_accept(acc), .cmd_reject(rej)
    );
    hpp_host_model i_hpp_host_model (
        .clk(clk), .style_dir(host_style), .host_data_out(dout), .host_data_oe(oe),
        .port_select_n(sel_n), .read_or_data_strobe_n(strb_n), .write_strobe_or_dir(wsd), .host_data_in(din)
    );

    // compare and count
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // verdict and end of run
    task automatic conclude();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial forever #50 clk = ~clk;

    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 50000) begin
            err_count++;
            conclude();
        end
    end

    // results pop the oldest note
    always @(posedge clk) begin
        if (rst_n && bw_v === 1'b1) check("boot_word", bq.size() ? bq.pop_front() : '1, {6'h0, bw_a, bw_d});
        if (rst_n && rx_v === 1'b1 && rx_rdy === 1'b1) check("rx_word", rq.size() ? rq.pop_front() : '1, {16'h0, rx_d});
        if (rst_n && (acc === 1'b1 || rej === 1'b1)) check("cmd_answer", cq.size() ? cq.pop_front() : '1, {30'h0, acc, rej});
    end

    initial begin
        logic [7:0] b, hi;
        hpp_word_t  w;
        void'($urandom(97));
        // pass 0: direction style, dmr; pass 1: separate strobes, dpmr
        for (int p = 0; p < 2; p++) begin
            rst_n = 1'b0;
            style_pin = (p == 0);
            host_style = (p == 0);
            dmr = (p == 0);
            repeat (10) @(negedge clk);
            check("reset_outputs", 0, {oe, stat, tx_rdy, done});
            rst_n = 1'b1;
            repeat (2) @(negedge clk);
            style_pin = !style_pin;  // strap moves after sampling
            for (int i = 0; i < 1024; i++) begin
                w = hpp_word_t'($urandom);
                bq.push_back({6'h0, i[9:0], w});
                i_hpp_host_model.wr_byte(w[7:0], 1'b1);
                i_hpp_host_model.wr_byte(w[15:8], 1'b1);
                if (i == 1022) check("status_in_boot", 0, stat);
            end
            repeat (6) @(negedge clk);
            check("boot_done", 1, done);
            check("boot_left", 0, bq.size());
            check("radio_mode", {31'h0, dmr}, {31'h0, mode});
            check("status_pending", 0, stat);
            for (int i = 0; i < 8; i++) begin
                i_hpp_host_model.rd_byte(b);
                check("resp_byte", RESP[63-8*i -: 8], b);
            end
            check("empty_status", 3, {oute, stat});
            // processor overfills transmit side
            for (int i = 0; i < 65; i++) begin
                tx_d = hpp_word_t'($urandom);
                tx_v = 1'b1;
                if (i < 64) tq.push_back({16'h0, tx_d});
                @(negedge clk);
            end
            tx_v = 1'b0;
            repeat (2) @(negedge clk);
            check("tx_full", 0, {tx_rdy, stat});
            for (int i = 0; i < 64; i++) begin
                i_hpp_host_model.rd_byte(hi);
                if (i == 63) check("empty_mid_pair", 0, oute);
                i_hpp_host_model.rd_byte(b);
                check("tx_word", tq.pop_front(), {16'h0, hi, b});
            end
            check("empty_status", 3, {oute, stat});
            // deselected strobes leave no trace
            rx_rdy = 1'b1;
            i_hpp_host_model.deselect();
            i_hpp_host_model.wr_byte(8'h5a, 1'b0);
            i_hpp_host_model.wr_byte(8'ha5, 1'b0);
            check("bus_released", 0, oe);
            rx_rdy = 1'b0;
            // host fills buffer and output stage
            for (int i = 0; i < 65; i++) begin
                w = hpp_word_t'($urandom);
                rq.push_back({16'h0, w});
                i_hpp_host_model.wr_byte(w[15:8], 1'b1);
                i_hpp_host_model.wr_byte(w[7:0], 1'b1);
                if (i == 63) check("full_early", 0, inf);
            end
            check("in_full", 3, {inf, stat});
            rx_rdy = 1'b1;
            for (int n = 0; n < 200 && rq.size() > 0; n++) @(negedge clk);
            rx_rdy = 1'b0;
            repeat (3) @(negedge clk);
            check("rx_drained", 0, {inf, 31'(rq.size())});
            // command screen by radio mode
            for (int i = 0; i < 3; i++) begin
                cmd_t = (i == 0) ? 8'h03 : ((i == 1) ? 8'h05 : 8'h0a);
                cq.push_back(((dmr && i == 0) || (!dmr && i == 1)) ? 32'h1 : 32'h2);
                cmd_v = 1'b1;
                @(negedge clk);
                cmd_v = 1'b0;
                repeat (2) @(negedge clk);
            end
            check("cmd_left", 0, cq.size());
        end
        conclude();
    end
endmodule
